// *** common/free_frame_pkg.sv ***
// constants, offsets and reset values for the free-format serial transmit port
package free_frame_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SEND_LEN = 8'h08;
    localparam logic [7:0] OFS_TX_CFG = 8'h0c;
    localparam logic [7:0] OFS_BREAK_BITS = 8'h10;
    localparam logic [7:0] OFS_IDLE_BITS = 8'h14;
    localparam logic [7:0] OFS_RTS_ON = 8'h18;
    localparam logic [7:0] OFS_RTS_OFF = 8'h1c;
    localparam logic [7:0] OFS_BAUD_DIV = 8'h20;
    localparam logic [7:0] OFS_DELIM_LO = 8'h24;
    localparam logic [7:0] OFS_DELIM_HI = 8'h28;
    localparam logic [7:0] OFS_RX_CFG = 8'h2c;
    localparam logic [7:0] OFS_BUF_ADDR = 8'h30;
    localparam logic [7:0] OFS_BUF_DATA = 8'h34;
    localparam logic [7:0] OFS_PORT_ID = 8'h38;
    // control fields
    localparam int CTRL_SEND_BIT = 0;
    localparam int CTRL_RX_ACK_BIT = 1;
    // transmit configuration fields
    localparam int CFG_BREAK_BIT = 0;
    localparam int CFG_IDLE_BIT = 1;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_TWO_DELIM_BIT = 4;
    localparam int CFG_SEVEN_BIT = 5;
    localparam int CFG_APPEND_LSB = 8;
    // end modes
    localparam logic [1:0] MODE_LENGTH = 2'h0;
    localparam logic [1:0] MODE_DELIM = 2'h1;
    localparam logic [1:0] MODE_APPEND = 2'h2;
    // static configuration, reloaded on every host restart
    localparam logic [11:0] TX_CFG_RST = 12'h100;
    localparam logic [15:0] BREAK_BITS_RST = 16'h000c;
    localparam logic [15:0] IDLE_BITS_RST = 16'h000c;
    localparam logic [15:0] RTS_ON_RST = 16'h0004;
    localparam logic [15:0] RTS_OFF_RST = 16'h0004;
    localparam logic [31:0] DELIM_LO_RST = 32'h0000_0a0d;
    localparam logic [7:0] DELIM_HI_RST = 8'h00;
    localparam logic [15:0] RX_CFG_RST = 16'h0000;
    // bit rate: divider derived from the clock and the default rate
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_RATE = 9600;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_RATE);
    // frame limits and process image sizes
    localparam logic [12:0] MAX_FRAME_BYTES = 13'h1000;
    localparam logic [12:0] PERF_TX_MAX = 13'd30;
    localparam logic [12:0] PERF_RX_MAX = 13'd24;
    localparam logic [5:0] PERF_IMAGE_IN = 6'd32;
    localparam logic [5:0] PERF_IMAGE_OUT = 6'd32;
    localparam logic [5:0] STD_IMAGE_IN = 6'd8;
    localparam logic [5:0] STD_IMAGE_OUT = 6'd0;
    // status codes
    localparam logic [3:0] ST_OK = 4'h0;
    localparam logic [3:0] ST_LEN_BAD = 4'h1;
    localparam logic [3:0] ST_CTS_TIMEOUT = 4'h2;
    localparam logic [3:0] ST_CTS_LOST = 4'h3;
    localparam logic [3:0] ST_RX_TOO_LONG = 4'h4;
    // arbitrary identifier value
    localparam logic [15:0] PORT_ID_VALUE = 16'h0a51;
    typedef enum logic [2:0] {
        S_IDLE, S_RTS_ON, S_BREAK, S_IDLE_LINE, S_DATA, S_RTS_OFF
    } tx_state_t;
endpackage : free_frame_pkg

// *** hdl/free_frame_serial_transmit.sv ***
// transmit framing, handshake and register port of the free-format serial port
//
// Function
// - performance mode: receive frames over 24, send frames over 30 bytes rejected
// - standard mode: frame length capped at the module maximum; code checks send length only, not received length
// - process image 32/32 bytes in performance mode, else 8 in, 0 out
// - performance mode comes only from static strap, never from register writes
// - host restart reloads all communication parameters from static values
// - runtime parameter writes act at once and are lost at restart
// - each rising edge of the send trigger sends the data area exactly once; edges arriving while tx_busy is high are ignored
// - failed send pulses error once and reports a status code
// - new-data flag rises when a received frame is stored for the host
// - payload may hold any 8-bit or 7-bit character value
// - start/end criteria kept separately for transmit and receive
// - optional break after RTS on delay, length in bit times
// - optional idle line at message start, length in bit times
// - break and idle preambles can each be switched off
// - after raising RTS wait the on delay before data
// - after the last character wait the off delay before dropping RTS
// - delimiter mode supports one or two configurable end delimiters
// - delimiter mode stops after the delimiter even if length is longer
// - append mode sends the length then one to five delimiter characters; code takes a count of 0 to 7 and repeats delim_hi for counts above 5
// - preamble order: RTS on delay, break, idle line, then data
// - RTS raised on send; CTS missing at end of on delay aborts with error
// - RTS dropped after off delay without waiting for CTS release
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module free_frame_serial_transmit
    import free_frame_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic host_restart,
    input wire logic perf_mode_strap,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic cts,
    output logic txd,
    output logic rts,
    input wire logic rx_store,
    input wire logic [12:0] rx_store_len,
    output logic new_data_flag,
    output logic tx_busy,
    output logic tx_done,
    output logic tx_error,
    output logic [3:0] status_code,
    output logic perf_mode,
    output logic [5:0] image_in_bytes,
    output logic [5:0] image_out_bytes
);
    // send buffer sized for the largest standard frame
    logic [7:0] mem [0:4095];
    logic [12:0] send_len;
    logic [11:0] tx_cfg;
    logic [15:0] break_bits;
    logic [15:0] idle_bits;
    logic [15:0] rts_on_bits;
    logic [15:0] rts_off_bits;
    logic [15:0] baud_div;
    logic [31:0] delim_lo;
    logic [7:0] delim_hi;
    logic [15:0] rx_cfg;
    logic [11:0] buf_addr;
    logic send_trig;
    logic send_trig_d;
    logic [15:0] baud_cnt;
    logic bit_tick;
    tx_state_t state;
    logic [15:0] phase_cnt;
    logic [9:0] shifter;
    logic [3:0] bit_cnt;
    logic [12:0] tx_idx;
    logic [2:0] app_idx;
    logic [7:0] prev_byte;
    logic delim_hit;
    logic [12:0] tx_limit;
    logic [1:0] end_mode;
    logic [2:0] append_cnt;
    logic in_payload;
    logic more;
    logic [7:0] next_byte;
    logic [9:0] next_frame;
    logic next_hit;
    logic send_edge;
    logic wr_cfg;

    // picks the idx-th appended delimiter character
    function automatic logic [7:0] delim_char(input logic [2:0] idx, input logic [31:0] lo,
                                              input logic [7:0] hi);
        logic [7:0] c;
        c = hi;
        if (idx < 3'd4) begin
            c = lo[8*idx +: 8];
        end
        return c;
    endfunction : delim_char

    assign end_mode = tx_cfg[CFG_MODE_LSB +: 2];
    assign append_cnt = tx_cfg[CFG_APPEND_LSB +: 3];
    assign tx_limit = perf_mode ? PERF_TX_MAX : MAX_FRAME_BYTES;
    assign send_edge = send_trig & ~send_trig_d;
    assign wr_cfg = wr & ~host_restart;

    // next character: payload first, then appended delimiters
    always_comb begin
        in_payload = (tx_idx < send_len) && !(end_mode == MODE_DELIM && delim_hit);
        more = in_payload;
        next_byte = mem[tx_idx[11:0]];
        if (!in_payload) begin
            more = (end_mode == MODE_APPEND) && (app_idx < append_cnt);
            next_byte = delim_char(app_idx, delim_lo, delim_hi);
        end
        // any value passes; 7-bit frames simply drop the top bit
        if (tx_cfg[CFG_SEVEN_BIT]) begin
            next_frame = {2'b11, next_byte[6:0], 1'b0};
        end else begin
            next_frame = {1'b1, next_byte, 1'b0};
        end
        // one delimiter, or the pair in order
        if (tx_cfg[CFG_TWO_DELIM_BIT]) begin
            next_hit = (prev_byte == delim_lo[7:0]) && (next_byte == delim_lo[15:8]);
        end else begin
            next_hit = (next_byte == delim_lo[7:0]);
        end
    end

    // bit-time enable pulse from the rate divider
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            baud_cnt <= 16'h0000;
            bit_tick <= 1'b0;
        end else if (baud_cnt == 16'h0000 || state == S_IDLE) begin
            baud_cnt <= (baud_div == 16'h0000) ? 16'h0000 : baud_div - 16'h0001;
            bit_tick <= (state != S_IDLE);
        end else begin
            baud_cnt <= baud_cnt - 16'h0001;
            bit_tick <= 1'b0;
        end
    end

    // communication parameters: static values at restart, runtime writes in between
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_cfg <= TX_CFG_RST;
            break_bits <= BREAK_BITS_RST;
            idle_bits <= IDLE_BITS_RST;
            rts_on_bits <= RTS_ON_RST;
            rts_off_bits <= RTS_OFF_RST;
            baud_div <= BAUD_DIV_RST;
            delim_lo <= DELIM_LO_RST;
            delim_hi <= DELIM_HI_RST;
            rx_cfg <= RX_CFG_RST;
        end else if (host_restart) begin
            tx_cfg <= TX_CFG_RST;
            break_bits <= BREAK_BITS_RST;
            idle_bits <= IDLE_BITS_RST;
            rts_on_bits <= RTS_ON_RST;
            rts_off_bits <= RTS_OFF_RST;
            baud_div <= BAUD_DIV_RST;
            delim_lo <= DELIM_LO_RST;
            delim_hi <= DELIM_HI_RST;
            rx_cfg <= RX_CFG_RST;
        end else if (wr_cfg) begin
            // takes effect at once; nothing is written back to the static set
            unique case (addr)
                OFS_TX_CFG: tx_cfg <= wdata[11:0];
                OFS_BREAK_BITS: break_bits <= wdata[15:0];
                OFS_IDLE_BITS: idle_bits <= wdata[15:0];
                OFS_RTS_ON: rts_on_bits <= wdata[15:0];
                OFS_RTS_OFF: rts_off_bits <= wdata[15:0];
                OFS_BAUD_DIV: baud_div <= wdata[15:0];
                OFS_DELIM_LO: delim_lo <= wdata;
                OFS_DELIM_HI: delim_hi <= wdata[7:0];
                OFS_RX_CFG: rx_cfg <= wdata[15:0];
                default: ;
            endcase
        end
    end

    // performance mode and image sizes follow only the strap, caught at restart
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            perf_mode <= 1'b0;
            image_in_bytes <= STD_IMAGE_IN;
            image_out_bytes <= STD_IMAGE_OUT;
        end else if (host_restart) begin
            perf_mode <= perf_mode_strap;
            image_in_bytes <= perf_mode_strap ? PERF_IMAGE_IN : STD_IMAGE_IN;
            image_out_bytes <= perf_mode_strap ? PERF_IMAGE_OUT : STD_IMAGE_OUT;
        end
    end

    // host-side request registers and send buffer loading
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            send_len <= 13'h0000;
            buf_addr <= 12'h000;
            send_trig <= 1'b0;
            send_trig_d <= 1'b0;
        end else begin
            send_trig_d <= send_trig;
            if (wr && addr == OFS_CTRL) begin
                send_trig <= wdata[CTRL_SEND_BIT];
            end
            if (wr && addr == OFS_SEND_LEN) begin
                send_len <= wdata[12:0];
            end
            if (wr && addr == OFS_BUF_ADDR) begin
                buf_addr <= wdata[11:0];
            end else if (wr && addr == OFS_BUF_DATA) begin
                buf_addr <= buf_addr + 12'h001;
            end
        end
    end

    // buffer array has no reset, so it maps onto plain memory
    always_ff @(posedge clk_sys) begin
        if (wr && addr == OFS_BUF_DATA) begin
            mem[buf_addr] <= wdata[7:0];
        end
    end

    // receive hand-off: flag stays until the host re-arms the receive
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            new_data_flag <= 1'b0;
        end else if (rx_store && (!perf_mode || rx_store_len <= PERF_RX_MAX)) begin
            new_data_flag <= 1'b1;
        end else if (wr && addr == OFS_CTRL && wdata[CTRL_RX_ACK_BIT]) begin
            new_data_flag <= 1'b0;
        end
    end

    // transmit sequencer: on delay, break, idle line, characters, off delay
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= S_IDLE;
            phase_cnt <= 16'h0000;
            shifter <= 10'h3ff;
            bit_cnt <= 4'h0;
            tx_idx <= 13'h0000;
            app_idx <= 3'h0;
            prev_byte <= 8'h00;
            delim_hit <= 1'b0;
            txd <= 1'b1;
            rts <= 1'b0;
            tx_busy <= 1'b0;
            tx_done <= 1'b0;
            tx_error <= 1'b0;
            status_code <= ST_OK;
        end else begin
            tx_done <= 1'b0;
            tx_error <= 1'b0;
            if (rx_store && perf_mode && rx_store_len > PERF_RX_MAX) begin
                tx_error <= 1'b1;
                status_code <= ST_RX_TOO_LONG;
            end
            unique case (state)
                S_IDLE: begin
                    txd <= 1'b1;
                    if (send_edge) begin
                        if (send_len == 13'h0000 || send_len > tx_limit) begin
                            tx_error <= 1'b1;
                            status_code <= ST_LEN_BAD;
                        end else begin
                            rts <= 1'b1;
                            tx_busy <= 1'b1;
                            status_code <= ST_OK;
                            phase_cnt <= rts_on_bits;
                            tx_idx <= 13'h0000;
                            app_idx <= 3'h0;
                            prev_byte <= 8'h00;
                            delim_hit <= 1'b0;
                            state <= S_RTS_ON;
                        end
                    end
                end
                S_RTS_ON: begin
                    if (bit_tick) begin
                        if (phase_cnt != 16'h0000) begin
                            phase_cnt <= phase_cnt - 16'h0001;
                        end else if (!cts) begin
                            rts <= 1'b0;
                            tx_busy <= 1'b0;
                            tx_error <= 1'b1;
                            status_code <= ST_CTS_TIMEOUT;
                            state <= S_IDLE;
                        end else if (tx_cfg[CFG_BREAK_BIT]) begin
                            txd <= 1'b0;
                            phase_cnt <= break_bits - 16'h0001;
                            state <= S_BREAK;
                        end else if (tx_cfg[CFG_IDLE_BIT]) begin
                            txd <= 1'b1;
                            phase_cnt <= idle_bits - 16'h0001;
                            state <= S_IDLE_LINE;
                        end else begin
                            phase_cnt <= 16'h0000;
                            state <= S_DATA;
                        end
                    end
                end
                S_BREAK: begin
                    if (bit_tick) begin
                        if (phase_cnt != 16'h0000) begin
                            phase_cnt <= phase_cnt - 16'h0001;
                        end else if (tx_cfg[CFG_IDLE_BIT]) begin
                            txd <= 1'b1;
                            phase_cnt <= idle_bits - 16'h0001;
                            state <= S_IDLE_LINE;
                        end else begin
                            txd <= 1'b1;
                            state <= S_DATA;
                        end
                    end
                end
                S_IDLE_LINE: begin
                    if (bit_tick) begin
                        if (phase_cnt != 16'h0000) begin
                            phase_cnt <= phase_cnt - 16'h0001;
                        end else begin
                            state <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    // a bit count of zero means the last stop bit just ended
                    if (bit_tick && rts && !cts) begin
                        txd <= 1'b1;
                        rts <= 1'b0;
                        tx_busy <= 1'b0;
                        tx_error <= 1'b1;
                        status_code <= ST_CTS_LOST;
                        state <= S_IDLE;
                    end else if (bit_tick && bit_cnt != 4'h0) begin
                        txd <= shifter[0];
                        shifter <= {1'b1, shifter[9:1]};
                        bit_cnt <= bit_cnt - 4'h1;
                    end else if (bit_tick && more) begin
                        // start bit goes out now, the rest follows on later ticks
                        txd <= 1'b0;
                        shifter <= {1'b1, next_frame[9:1]};
                        bit_cnt <= tx_cfg[CFG_SEVEN_BIT] ? 4'h8 : 4'h9;
                        if (in_payload) begin
                            tx_idx <= tx_idx + 13'h0001;
                            prev_byte <= next_byte;
                            delim_hit <= next_hit;
                        end else begin
                            app_idx <= app_idx + 3'h1;
                        end
                    end else if (bit_tick) begin
                        txd <= 1'b1;
                        phase_cnt <= rts_off_bits;
                        state <= S_RTS_OFF;
                    end
                end
                S_RTS_OFF: begin
                    if (bit_tick) begin
                        if (phase_cnt != 16'h0000) begin
                            phase_cnt <= phase_cnt - 16'h0001;
                        end else begin
                            rts <= 1'b0;
                            tx_busy <= 1'b0;
                            tx_done <= 1'b1;
                            state <= S_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // read port: data stands in the cycle after the strobe only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else if (!rd) begin
            rdata <= 32'h0000_0000;
        end else begin
            unique case (addr)
                OFS_CTRL: rdata <= {30'h0000_0000, 1'b0, send_trig};
                OFS_STATUS: rdata <= {20'h00000, status_code, 3'h0, perf_mode,
                                      new_data_flag, rts, tx_busy, 1'b0};
                OFS_SEND_LEN: rdata <= {19'h00000, send_len};
                OFS_TX_CFG: rdata <= {20'h00000, tx_cfg};
                OFS_BREAK_BITS: rdata <= {16'h0000, break_bits};
                OFS_IDLE_BITS: rdata <= {16'h0000, idle_bits};
                OFS_RTS_ON: rdata <= {16'h0000, rts_on_bits};
                OFS_RTS_OFF: rdata <= {16'h0000, rts_off_bits};
                OFS_BAUD_DIV: rdata <= {16'h0000, baud_div};
                OFS_DELIM_LO: rdata <= delim_lo;
                OFS_DELIM_HI: rdata <= {24'h000000, delim_hi};
                OFS_RX_CFG: rdata <= {16'h0000, rx_cfg};
                OFS_BUF_ADDR: rdata <= {20'h00000, buf_addr};
                OFS_PORT_ID: rdata <= {16'h0000, PORT_ID_VALUE};
                default: rdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : free_frame_serial_transmit

// *** testbench/free_frame_asserts.sv ***
// pin-level checks for the serial transmit port
`timescale 1ns/1ps
module free_frame_asserts
    import free_frame_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic host_restart,
    input wire logic perf_mode_strap,
    input wire logic rx_store,
    input wire logic [12:0] rx_store_len,
    input wire logic txd,
    input wire logic rts,
    input wire logic new_data_flag,
    input wire logic tx_busy,
    input wire logic tx_done,
    input wire logic tx_error,
    input wire logic [3:0] status_code,
    input wire logic perf_mode,
    input wire logic [5:0] image_in_bytes,
    input wire logic [5:0] image_out_bytes
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // image size is loaded in the same cycle as the mode
    a_image_size: assert property (!host_restart && $stable(perf_mode) |->
        image_in_bytes == (perf_mode ? PERF_IMAGE_IN : STD_IMAGE_IN) &&
        image_out_bytes == (perf_mode ? PERF_IMAGE_OUT : STD_IMAGE_OUT)) else $error("image size");
    a_mode_static: assert property (!host_restart |=> $stable(perf_mode))
        else $error("mode changed without restart");
    a_mode_reload: assert property (host_restart |=> perf_mode == $past(perf_mode_strap))
        else $error("strap not loaded");
    a_error_once: assert property (tx_error |=> !tx_error) else $error("error pulse long");
    a_done_once: assert property (tx_done |=> !tx_done) else $error("done pulse long");
    a_done_rts: assert property (tx_done |-> !rts && !tx_busy) else $error("rts at done");
    a_idle_mark: assert property (!tx_busy && !rts |-> txd) else $error("line not mark");
    // on delay is at least two bit ticks of four cycles here
    a_on_delay: assert property ($rose(rts) |-> txd [*8]) else $error("data before delay");
    a_rx_reject: assert property (rx_store && perf_mode && rx_store_len > PERF_RX_MAX |=>
        tx_error && status_code == ST_RX_TOO_LONG) else $error("long frame kept");
    a_rx_flag: assert property (rx_store && !(perf_mode && rx_store_len > PERF_RX_MAX) |=>
        new_data_flag) else $error("flag not set");
    c_done: cover property (tx_done);
    c_cts_fail: cover property (tx_error && status_code == ST_CTS_TIMEOUT);
    c_flag: cover property ($rose(new_data_flag));
endmodule : free_frame_asserts

bind free_frame_serial_transmit free_frame_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst),
    .host_restart(host_restart), .perf_mode_strap(perf_mode_strap), .rx_store(rx_store),
    .rx_store_len(rx_store_len), .txd(txd), .rts(rts), .new_data_flag(new_data_flag),
    .tx_busy(tx_busy), .tx_done(tx_done), .tx_error(tx_error), .status_code(status_code),
    .perf_mode(perf_mode), .image_in_bytes(image_in_bytes), .image_out_bytes(image_out_bytes));

// *** testbench/serial_partner.sv ***
// far-side partner: clear-to-send answer and character decoder
`timescale 1ns/1ps
module serial_partner #(
    parameter int BIT = 4
) (
    input wire logic clk_sys,
    input wire logic rts,
    input wire logic txd,
    input wire logic allow,
    output logic cts,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    int i;
    logic [7:0] sh;
    initial cts = 1'b0;
    initial rx_valid = 1'b0;
    // answer follows request; withheld when the bench forbids it
    always @(posedge clk_sys) begin
        cts <= rts && allow;
    end
    // mid-bit sampling; a break fails the stop bit and is skipped
    always begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk_sys);
        if (!txd) begin
            for (i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_sys);
                sh[i] = txd;
            end
            repeat (BIT) @(posedge clk_sys);
            if (txd) begin
                rx_byte <= sh;
                rx_valid <= 1'b1;
                @(posedge clk_sys);
                rx_valid <= 1'b0;
            end else begin
                wait (txd);
            end
        end
    end
endmodule : serial_partner

// *** testbench/tb_free_frame_serial_transmit.sv ***
// self-checking bench for the serial transmit port
`timescale 1ns/1ps
module tb_free_frame_serial_transmit
    import free_frame_pkg::*;
;
    logic clk_sys = 1'b0, nrst = 1'b0, host_restart = 1'b0, perf_mode_strap = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rx_store = 1'b0, allow = 1'b1, rd_d = 1'b0;
    logic [7:0] addr = 8'h00, rx_byte, pay[$];
    logic [12:0] rx_store_len = 13'h0;
    logic cts, txd, rts, new_data_flag, tx_busy, tx_done, tx_error, perf_mode, rx_valid;
    logic [3:0] status_code;
    logic [5:0] image_in_bytes, image_out_bytes;
    logic [15:0] lfsr = 16'd5395;
    logic [31:0] wdata = 32'h0, rdata, q_rd[$], q_byte[$], q_stat[$];
    int fails = 0, num_checks = 0, cycles = 0, k;
    free_frame_serial_transmit dut (.clk_sys(clk_sys), .nrst(nrst), .host_restart(host_restart),
        .perf_mode_strap(perf_mode_strap), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cts(cts), .txd(txd), .rts(rts), .rx_store(rx_store),
        .rx_store_len(rx_store_len), .new_data_flag(new_data_flag), .tx_busy(tx_busy),
        .tx_done(tx_done), .tx_error(tx_error), .status_code(status_code), .perf_mode(perf_mode),
        .image_in_bytes(image_in_bytes), .image_out_bytes(image_out_bytes));
    serial_partner #(.BIT(4)) u_partner (.clk_sys(clk_sys), .rts(rts), .txd(txd), .allow(allow),
        .cts(cts), .rx_valid(rx_valid), .rx_byte(rx_byte));
    initial forever #20 clk_sys = ~clk_sys;
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic summarize();
        if (fails == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // a spare edge after each strobe keeps drives one per time step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        addr <= a; rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(posedge clk_sys);
    endtask : rd_reg
    task automatic restart(input logic s);
        perf_mode_strap <= s; host_restart <= 1'b1;
        @(posedge clk_sys);
        host_restart <= 1'b0;
        @(posedge clk_sys);
    endtask : restart
    task automatic load();
        wr_reg(OFS_BUF_ADDR, 32'h0);
        foreach (pay[j]) wr_reg(OFS_BUF_DATA, {24'h0, pay[j]});
    endtask : load
    task automatic send(input logic [12:0] len, input logic [3:0] st);
        q_stat.push_back({28'h0, st});
        allow <= (st != ST_CTS_TIMEOUT);
        wr_reg(OFS_SEND_LEN, {19'h0, len});
        wr_reg(OFS_CTRL, 32'h1);
        while (!(tx_done || tx_error)) @(posedge clk_sys);
        wr_reg(OFS_CTRL, 32'h0);
    endtask : send
    task automatic rx(input logic [12:0] len, input logic [31:0] flag);
        rx_store_len <= len; rx_store <= 1'b1;
        @(posedge clk_sys);
        rx_store <= 1'b0;
        @(posedge clk_sys);
        chk("new_data_flag", flag, {31'h0, new_data_flag});
    endtask : rx
    // watcher: oldest note against each result, plus the hang limit
    always @(posedge clk_sys) begin
        rd_d <= rd;
        if (nrst && rd_d) chk("rdata", q_rd.pop_front(), rdata);
        if (nrst && rx_valid) chk("byte", q_byte.pop_front(), {24'h0, rx_byte});
        if (nrst && (tx_done || tx_error)) chk("status", q_stat.pop_front(), {28'h0, status_code});
        cycles++;
        if (cycles == 60000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        chk("image", {26'h0, STD_IMAGE_IN}, {26'h0, image_in_bytes});
        chk("pins", 32'h2, {30'h0, txd, rts});
        rd_reg(OFS_PORT_ID, {16'h0, PORT_ID_VALUE});
        rd_reg(8'hfc, 32'h0);
        wr_reg(OFS_TX_CFG, 32'h3);
        rd_reg(OFS_TX_CFG, 32'h3);
        restart(1'b1);
        rd_reg(OFS_TX_CFG, {20'h0, TX_CFG_RST});
        chk("image", {26'h0, PERF_IMAGE_OUT}, {26'h0, image_out_bytes});
        wr_reg(OFS_BAUD_DIV, 32'h4); wr_reg(OFS_RTS_ON, 32'h2); wr_reg(OFS_RTS_OFF, 32'h1);
        // full-size frame with break and idle, extremes then random
        wr_reg(OFS_TX_CFG, 32'h3);
        pay = '{8'h00, 8'hff};
        for (k = 2; k < 30; k++) pay.push_back(rnd());
        foreach (pay[j]) q_byte.push_back({24'h0, pay[j]});
        load();
        send(13'd30, ST_OK);
        send(13'd31, ST_LEN_BAD);
        send(13'd0, ST_LEN_BAD);
        pay = '{8'h41, 8'h0d, 8'h42};
        q_byte.push_back(32'h41); q_byte.push_back(32'h0d);
        wr_reg(OFS_TX_CFG, 32'h4);
        load();
        send(13'd3, ST_OK);
        pay = '{8'h31};
        q_byte.push_back(32'h31); q_byte.push_back(32'h0d); q_byte.push_back(32'h0a);
        wr_reg(OFS_TX_CFG, 32'h208);
        load();
        send(13'd1, ST_OK);
        send(13'd1, ST_CTS_TIMEOUT);
        rx(13'd24, 32'h1);
        wr_reg(OFS_CTRL, 32'h2);
        q_stat.push_back({28'h0, ST_RX_TOO_LONG});
        rx(13'd25, 32'h0);
        restart(1'b0);
        send(13'h1001, ST_LEN_BAD);
        chk("left", 32'h0, 32'(q_byte.size() + q_stat.size()));
        summarize();
    end
endmodule : tb_free_frame_serial_transmit
